// *** shared/pco_pkg.sv ***
package pco_pkg;
  localparam int POS_W = 16;
  localparam int DIGITS = 5;
  localparam int WORD_W = 4 * DIGITS;
  localparam int SETTLE_CYC = 4;
  localparam logic [3:0] GRAY_NEXT_HALF = 4'h5;
  typedef enum logic [1:0] {
    PCO_BINARY,
    PCO_BCD,
    PCO_GRAY,
    PCO_XS3GRAY
  } pco_code_e;
  // first-decade excess-3 gray table, digit 0 to 9
  localparam logic [39:0] XS3_TABLE = {
    4'hA, 4'hE, 4'hF, 4'hD, 4'hC, 4'h4, 4'h5, 4'h7, 4'h6, 4'h2
  };
endpackage : pco_pkg

// *** shared/pco_link_if.sv ***
`timescale 1ns/1ns
interface pco_link_if;
  logic [pco_pkg::WORD_W-1:0] data;
  logic [pco_pkg::WORD_W-1:0] data_oe_b;
  logic latch;
  logic tristate;
  modport dev (output data, output data_oe_b, input latch, input tristate);
  modport rcv (input data, input data_oe_b, output latch, output tristate);
endinterface : pco_link_if

// *** design/pco_encoder_out.sv ***
`timescale 1ns/1ns
// Functional notes
// - excess-3 gray decade code, one-bit steps
// - 8421 digit groups, reflected after odd
// - clipped excess-3 gray variant for wrap
// - round range up, add half gap
// - receiver subtracts same offset after decode
// - clipping only with zero lower range
// - outputs show coded position, word held while latch is high
// - tristate input releases the shared bus
// - receiver expects glitches on multi-step codes
// - receiver sampling is unsynchronised to updates
// - filter: read twice, accept on match
// - mismatch: take third read unchecked
// - keep waits between filter reads short
// - receiver drives latch at correct level
// - receiver waits before sampling after latch
// - BCD code, first decade lowest
// - reflected binary gray code offered
module pco_encoder_out #(
  parameter int RANGE = 720,
  parameter logic [pco_pkg::POS_W-1:0] LOWER = '0
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [pco_pkg::POS_W-1:0] POS_IN,
  input wire logic [1:0] CODE_SEL_IN,
  input wire logic CLIP_EN_IN,
  output logic CLIP_ACTIVE_OUT,
  pco_link_if.dev LINK
);
  localparam int W = pco_pkg::WORD_W;
  // power of ten at or above range
  function automatic int pow10_ceil(input int r);
    int p;
    p = 1;
    while (p < r) p = p * 10;
    return p;
  endfunction : pow10_ceil
  localparam int P10 = pow10_ceil(RANGE);
  localparam int P2 = 2 ** $clog2(RANGE);
  localparam logic [pco_pkg::POS_W-1:0] OFS10 =
    pco_pkg::POS_W'((P10 - RANGE) / 2);
  localparam logic [pco_pkg::POS_W-1:0] OFS2 =
    pco_pkg::POS_W'((P2 - RANGE) / 2);

  logic [W-1:0] word_q, word_d;
  logic [W-1:0] oe_b_q, oe_b_d;
  logic clip_q, clip_d;
  logic [pco_pkg::POS_W-1:0] pos;
  logic [4*pco_pkg::DIGITS-1:0] bcd;
  logic [W-1:0] xs3, code;
  logic [pco_pkg::DIGITS:0] odd;

  // binary to BCD by digit division
  always_comb begin
    logic [pco_pkg::POS_W-1:0] v;
    v = pos;
    for (int i = 0; i < pco_pkg::DIGITS; i++) begin
      bcd[4*i +: 4] = 4'(v % 10);
      v = pco_pkg::POS_W'(v / 10);
    end
  end

  assign odd[pco_pkg::DIGITS] = 1'b0;
  generate
    for (genvar g = 0; g < pco_pkg::DIGITS; g++) begin : g_dig
      logic [3:0] d, m;
      assign d = bcd[4*g +: 4];
      // value above is odd exactly when its lowest digit is odd
      assign odd[g] = d[0];
      assign m = odd[g+1] ? 4'(9 - d) : d;
      assign xs3[4*g +: 4] = pco_pkg::XS3_TABLE[4*m +: 4];
    end
  endgenerate

  always_comb begin
    clip_d = CLIP_EN_IN && (LOWER == '0);
    pos = POS_IN;
    if (clip_q) begin
      if (CODE_SEL_IN == pco_pkg::PCO_XS3GRAY)
        pos = POS_IN + OFS10;
      else if (CODE_SEL_IN == pco_pkg::PCO_GRAY)
        pos = POS_IN + OFS2;
    end
  end

  always_comb begin
    case (pco_pkg::pco_code_e'(CODE_SEL_IN))
      pco_pkg::PCO_BINARY: code = W'(pos);
      pco_pkg::PCO_BCD: code = bcd;
      pco_pkg::PCO_GRAY: code = W'(pos ^ (pos >> 1));
      pco_pkg::PCO_XS3GRAY: code = xs3;
      default: code = W'(pos);
    endcase
  end

  always_comb begin
    word_d = code;
    if (LINK.latch)
      word_d = word_q;
    oe_b_d = LINK.tristate ? '1 : '0;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      word_q <= '0;
      oe_b_q <= '1;
      clip_q <= 1'b0;
    end else begin
      word_q <= word_d;
      oe_b_q <= oe_b_d;
      clip_q <= clip_d;
    end
  end

  assign LINK.data = word_q;
  assign LINK.data_oe_b = oe_b_q;
  assign CLIP_ACTIVE_OUT = clip_q;
endmodule : pco_encoder_out

// *** design/pco_receiver.sv ***
`timescale 1ns/1ns
// double-read filter with optional latch mode, decodes to binary
module pco_receiver #(
  parameter int RANGE = 720
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic READ_IN,
  input wire logic USE_LATCH_IN,
  input wire logic BUS_EN_IN,
  input wire logic [1:0] CODE_SEL_IN,
  input wire logic CLIP_IN,
  output logic [pco_pkg::POS_W-1:0] POS_OUT,
  output logic VALID_OUT,
  output logic BUSY_OUT,
  pco_link_if.rcv LINK
);
  localparam int W = pco_pkg::WORD_W;
  function automatic int pow10_ceil(input int r);
    int p;
    p = 1;
    while (p < r) p = p * 10;
    return p;
  endfunction : pow10_ceil
  localparam logic [pco_pkg::POS_W-1:0] OFS10 =
    pco_pkg::POS_W'((pow10_ceil(RANGE) - RANGE) / 2);
  localparam logic [pco_pkg::POS_W-1:0] OFS2 =
    pco_pkg::POS_W'((2 ** $clog2(RANGE) - RANGE) / 2);

  typedef enum logic [2:0] {
    S_IDLE, S_FIRST, S_SECOND, S_THIRD, S_LATCH_WAIT
  } pco_rx_e;
  pco_rx_e st_q, st_d;
  logic [W-1:0] s1_q, s1_d;
  logic [2:0] cnt_q, cnt_d;
  logic [pco_pkg::POS_W-1:0] pos_q, pos_d;
  logic valid_q, valid_d, latch_q, latch_d;
  logic busy_q, busy_d, tri_q, tri_d;
  logic take;
  logic [W-1:0] w;
  logic [pco_pkg::POS_W-1:0] dec;

  // decode word to binary position, clipped offset removed
  always_comb begin
    logic [3:0] m, d;
    logic par;
    logic [pco_pkg::POS_W-1:0] g, v;
    v = '0;
    g = '0;
    par = 1'b0;
    m = '0;
    d = '0;
    case (CODE_SEL_IN)
      2'h1: for (int i = pco_pkg::DIGITS - 1; i >= 0; i--)
        v = pco_pkg::POS_W'(v * 10 + w[4*i +: 4]);
      2'h2: begin
        g = w[pco_pkg::POS_W-1:0];
        for (int i = pco_pkg::POS_W - 1; i >= 0; i--) begin
          par = par ^ g[i];
          v[i] = par;
        end
      end
      2'h3: for (int i = pco_pkg::DIGITS - 1; i >= 0; i--) begin
        m = 4'h0;
        for (int k = 0; k < 10; k++)
          if (pco_pkg::XS3_TABLE[4*k +: 4] == w[4*i +: 4])
            m = 4'(k);
        d = par ? 4'(9 - m) : m;
        // next digit reflects when the value above it is odd
        par = d[0];
        v = pco_pkg::POS_W'(v * 10 + d);
      end
      default: v = w[pco_pkg::POS_W-1:0];
    endcase
    dec = v;
    if (CLIP_IN && CODE_SEL_IN == 2'h3)
      dec = v - OFS10;
    else if (CLIP_IN && CODE_SEL_IN == 2'h2)
      dec = v - OFS2;
  end

  assign w = LINK.data;

  always_comb begin
    st_d = st_q;
    s1_d = s1_q;
    cnt_d = cnt_q;
    pos_d = pos_q;
    valid_d = 1'b0;
    latch_d = latch_q;
    take = 1'b0;
    case (st_q)
      S_IDLE: if (READ_IN) begin
        if (USE_LATCH_IN) begin
          latch_d = 1'b1;
          cnt_d = 3'(pco_pkg::SETTLE_CYC);
          st_d = S_LATCH_WAIT;
        end else begin
          st_d = S_FIRST;
        end
      end
      S_FIRST: begin
        s1_d = w;
        st_d = S_SECOND;
      end
      S_SECOND: begin
        if (w == s1_q) begin
          take = 1'b1;
          st_d = S_IDLE;
        end else begin
          st_d = S_THIRD;
        end
      end
      S_THIRD: begin
        take = 1'b1;
        st_d = S_IDLE;
      end
      S_LATCH_WAIT: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h0) begin
          take = 1'b1;
          latch_d = 1'b0;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (take) begin
      pos_d = dec;
      valid_d = 1'b1;
    end
    busy_d = (st_d != S_IDLE);
    // registered pin: tristate lags the request by one cycle, bus release at the encoder by two
    tri_d = !BUS_EN_IN;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_q <= S_IDLE;
      s1_q <= '0;
      cnt_q <= '0;
      pos_q <= '0;
      valid_q <= 1'b0;
      latch_q <= 1'b0;
      busy_q <= 1'b0;
      tri_q <= 1'b0;
    end else begin
      st_q <= st_d;
      s1_q <= s1_d;
      cnt_q <= cnt_d;
      pos_q <= pos_d;
      valid_q <= valid_d;
      latch_q <= latch_d;
      busy_q <= busy_d;
      tri_q <= tri_d;
    end
  end

  assign LINK.latch = latch_q;
  assign LINK.tristate = tri_q;
  assign BUSY_OUT = busy_q;
  assign POS_OUT = pos_q;
  assign VALID_OUT = valid_q;
endmodule : pco_receiver

// *** tb/pco_link_checker.sv ***
`timescale 1ns/1ns
module pco_link_checker (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [pco_pkg::WORD_W-1:0] data_in,
  input wire logic [pco_pkg::WORD_W-1:0] data_oe_b_in,
  input wire logic latch_in,
  input wire logic tristate_in
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  AST_TRI_OFF: assert property (tristate_in |=> &data_oe_b_in)
    else $error("bus not released");
  AST_TRI_ON: assert property (!tristate_in |=> data_oe_b_in == '0)
    else $error("bus not driven");
  AST_OE_WHOLE: assert property (&data_oe_b_in || data_oe_b_in == '0)
    else $error("partial word drive");
  AST_HOLD: assert property (latch_in ##1 latch_in |=> $stable(data_in))
    else $error("word moved while frozen");
  AST_HOLD3: assert property (latch_in [*3] |-> $stable(data_in))
    else $error("frozen word drifted");
  // four cycles is the settle time the receiver must allow
  AST_LATCH_MIN: assert property ($rose(latch_in) |-> latch_in [*4])
    else $error("latch released too early");
  AST_LATCH_END: assert property ($rose(latch_in) |-> ##[4:8] !latch_in)
    else $error("latch stuck high");
  AST_LATCH_SEEN: assert property ($rose(latch_in) |=> $stable(data_in))
    else $error("word moved after latch");
  cover property ($rose(latch_in));
  cover property ($rose(tristate_in));
  cover property ($fell(latch_in) ##1 !tristate_in);
endmodule : pco_link_checker

// *** tb/tb_position_code_output.sv ***
`timescale 1ns/1ns
module tb_position_code_output;
  localparam int RNG = 720;
  logic CLK_IN = 0;
  logic RST_B_IN = 0;
  logic [15:0] pos = 0;
  logic [15:0] pos_o;
  logic [1:0] code = 0;
  logic clip = 0, rd_go = 0, use_l = 0, bus_en = 1;
  logic vld, busy, clip_act;
  logic [19:0] prev;
  int fails = 0, tests_run = 0, seed = 69370;
  pco_link_if i_pco_link_if ();
  pco_encoder_out #(.RANGE(RNG)) i_pco_encoder_out (.CLK_IN(CLK_IN),
    .RST_B_IN(RST_B_IN), .POS_IN(pos), .CODE_SEL_IN(code),
    .CLIP_EN_IN(clip), .CLIP_ACTIVE_OUT(clip_act), .LINK(i_pco_link_if));
  pco_receiver #(.RANGE(RNG)) i_pco_receiver (.CLK_IN(CLK_IN),
    .RST_B_IN(RST_B_IN), .READ_IN(rd_go), .USE_LATCH_IN(use_l),
    .BUS_EN_IN(bus_en), .CODE_SEL_IN(code), .CLIP_IN(clip),
    .POS_OUT(pos_o), .VALID_OUT(vld), .BUSY_OUT(busy),
    .LINK(i_pco_link_if));
  pco_link_checker i_pco_link_checker (.CLK_IN(CLK_IN),
    .RST_B_IN(RST_B_IN), .data_in(i_pco_link_if.data),
    .data_oe_b_in(i_pco_link_if.data_oe_b),
    .latch_in(i_pco_link_if.latch),
    .tristate_in(i_pco_link_if.tristate));
  always #5 CLK_IN = ~CLK_IN;
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [19:0] enc(int p, int c, logic cl);
    logic [19:0] w;
    int v;
    int q;
    q = 1;
    while (q < RNG) q = q * ((c == 2) ? 2 : 10);
    if (cl && c > 1) p = p + (q - RNG) / 2;
    v = p;
    for (int i = 0; i < 5; i++) begin
      w[4*i+:4] = (c == 1) ? 4'(v % 10) : pco_pkg::XS3_TABLE[4 *
        (((v / 10) % 2 == 1) ? 9 - v % 10 : v % 10)+:4];
      v = v / 10;
    end
    if (c == 0) w = 20'(p);
    if (c == 2) w = 20'(p ^ (p >> 1));
    return w;
  endfunction : enc
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic put(int p);
    pos = 16'(p);
    repeat (3) @(negedge CLK_IN);
    chk("data", 32'(i_pco_link_if.data), 32'(enc(p, code, clip)));
  endtask : put
  // bd is the wait before pos moves mid-read; -1 keeps it still
  task automatic rd(int nxt, int bd, int exp);
    rd_go = 1;
    @(negedge CLK_IN);
    rd_go = 0;
    chk("busy", 32'(busy), 1);
    for (int n = 0; n < 30 && vld !== 1'b1; n++) begin
      if (n == bd) pos = 16'(nxt);
      @(negedge CLK_IN);
    end
    chk("valid", 32'(vld), 1);
    chk("idle", 32'(busy), 0);
    chk("pos", 32'(pos_o), 32'(exp));
    repeat (2) @(negedge CLK_IN);
  endtask : rd
  initial begin
    int p;
    repeat (16) @(negedge CLK_IN);
    RST_B_IN = 1;
    @(negedge CLK_IN);
    for (int m = 0; m < 8; m++) begin
      code = 2'(m);
      clip = m[2];
      for (int k = 0; k < 27; k++) begin
        p = (k < 9) ? (716 + k) % RNG : (k < 22) ? k - 1 :
          (rnd() & 32'h3FF) % RNG;
        put(p);
        if (k > 0 && k != 9 && k < 22 && code[1] && (clip || p != 0))
          chk("step", 32'($countones(prev ^ i_pco_link_if.data)), 1);
        prev = i_pco_link_if.data;
        rd(0, -1, p);
      end
      chk("clip", 32'(clip_act), 32'(clip));
      rd(5, 0, 5);
      use_l = 1;
      rd(6, 2, 5);
      use_l = 0;
      bus_en = 0;
      repeat (2) @(negedge CLK_IN);
      chk("oe", 32'(&i_pco_link_if.data_oe_b), 1);
      bus_en = 1;
      repeat (2) @(negedge CLK_IN);
      chk("drive", 32'(|i_pco_link_if.data_oe_b), 0);
    end
    test_done();
  end
  initial begin
    #300000;
    fails++;
    test_done();
  end
endmodule : tb_position_code_output
